//--- padv_mgmt_regs.sv
`timescale 1ns/1ps
// ==========================================================
// Identifier and advertisement registers behind the management pins
module padv_mgmt_regs #(
  parameter logic [23:0] OUI_VALUE = 24'h5a3c96, // Arbitrary value
  parameter logic [5:0] MODEL_VALUE = 6'h2b, // Arbitrary value
  parameter logic [3:0] REVISION_VALUE = 4'h7 // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  input wire logic cmd_override,
  input wire logic config_source_pin,
  input wire logic an_enable,
  input wire logic lcw_load,
  input wire logic lcw_shift,
  output logic [15:0] lcw_word,
  output logic lcw_bit,
  output logic [15:0] adv_view
);

  localparam padv_pkg::padv_ident_s IDENT_RESET =
    padv_pkg::padv_ident_reset(OUI_VALUE, MODEL_VALUE, REVISION_VALUE);

  // ==========================================================
  // Declarations
  logic mdc_rise;
  padv_pkg::padv_smi_state_e state;
  logic [4:0] bit_cnt;
  logic [5:0] pre_cnt;
  padv_pkg::padv_frame_s frame;
  logic [15:0] shift_in;
  logic [15:0] rd_shift;
  logic [4:0] regad_full;
  logic [15:0] wr_data;
  logic last_bit;
  logic frame_hit;
  logic rd_hit;
  logic wr_stb;
  logic [15:0] rd_value;
  logic [15:0] phy_ident_upper;
  logic [15:0] phy_ident_lower;
  logic [15:0] autoneg_advertise;
  logic [15:0] adv_wmask;

  padv_mdc_edge u_edge (
    .ref_clk(ref_clk),
    .rst(rst),
    .mdc(mdc),
    .mdc_rise(mdc_rise)
  );

  // ==========================================================
  // Frame decode helpers
  assign regad_full = {frame.regad[3:0], mdio_in};
  assign wr_data = {shift_in[14:0], mdio_in};
  assign frame_hit = (frame.phyad == phy_addr) &&
                     ((regad_full == padv_pkg::PADV_REG_IDENT_UPPER) ||
                      (regad_full == padv_pkg::PADV_REG_IDENT_LOWER) ||
                      (regad_full == padv_pkg::PADV_REG_ADVERTISE));
  assign last_bit = mdc_rise && (state == padv_pkg::PADV_S_REGAD) &&
                    (bit_cnt == padv_pkg::PADV_LEN_ADDR);
  // Only our three registers are answered; other slices of the PHY answer theirs
  assign rd_hit = last_bit && frame_hit && (frame.op == padv_pkg::PADV_OP_READ);
  assign wr_stb = mdc_rise && (state == padv_pkg::PADV_S_DATA) &&
                  (bit_cnt == padv_pkg::PADV_LEN_DATA) &&
                  (frame.op == padv_pkg::PADV_OP_WRITE) && (frame.phyad == phy_addr);

  // ==========================================================
  // Management frame sequencer, advanced on each mdc rising edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= padv_pkg::PADV_S_PREAMBLE;
      bit_cnt <= '0;
      pre_cnt <= '0;
    end else if (mdc_rise) begin
      case (state)
        padv_pkg::PADV_S_PREAMBLE: begin
          if (mdio_in) begin
            if (pre_cnt != padv_pkg::PADV_PREAMBLE_LEN) begin
              pre_cnt <= pre_cnt + 6'h01;
            end
          end else begin
            // A zero after a full preamble is the first start bit
            if (pre_cnt == padv_pkg::PADV_PREAMBLE_LEN) begin
              state <= padv_pkg::PADV_S_START;
            end
            pre_cnt <= '0;
          end
        end
        padv_pkg::PADV_S_START: begin
          bit_cnt <= '0;
          state <= mdio_in ? padv_pkg::PADV_S_OP : padv_pkg::PADV_S_PREAMBLE;
        end
        padv_pkg::PADV_S_OP: begin
          bit_cnt <= (bit_cnt == padv_pkg::PADV_LEN_OP) ? 5'h00 : bit_cnt + 5'h01;
          if (bit_cnt == padv_pkg::PADV_LEN_OP) begin
            state <= padv_pkg::PADV_S_PHYAD;
          end
        end
        padv_pkg::PADV_S_PHYAD: begin
          bit_cnt <= (bit_cnt == padv_pkg::PADV_LEN_ADDR) ? 5'h00 : bit_cnt + 5'h01;
          if (bit_cnt == padv_pkg::PADV_LEN_ADDR) begin
            state <= padv_pkg::PADV_S_REGAD;
          end
        end
        padv_pkg::PADV_S_REGAD: begin
          bit_cnt <= (bit_cnt == padv_pkg::PADV_LEN_ADDR) ? 5'h00 : bit_cnt + 5'h01;
          if (bit_cnt == padv_pkg::PADV_LEN_ADDR) begin
            // Illegal opcodes drop back to hunting for preamble
            if (frame.op == padv_pkg::PADV_OP_READ || frame.op == padv_pkg::PADV_OP_WRITE) begin
              state <= padv_pkg::PADV_S_TA;
            end else begin
              state <= padv_pkg::PADV_S_PREAMBLE;
            end
          end
        end
        padv_pkg::PADV_S_TA: begin
          bit_cnt <= (bit_cnt == padv_pkg::PADV_LEN_TA) ? 5'h00 : bit_cnt + 5'h01;
          if (bit_cnt == padv_pkg::PADV_LEN_TA) begin
            state <= padv_pkg::PADV_S_DATA;
          end
        end
        padv_pkg::PADV_S_DATA: begin
          bit_cnt <= (bit_cnt == padv_pkg::PADV_LEN_DATA) ? 5'h00 : bit_cnt + 5'h01;
          if (bit_cnt == padv_pkg::PADV_LEN_DATA) begin
            state <= padv_pkg::PADV_S_PREAMBLE;
            pre_cnt <= '0;
          end
        end
        default: begin
          state <= padv_pkg::PADV_S_PREAMBLE;
          bit_cnt <= '0;
          pre_cnt <= '0;
        end
      endcase
    end
  end

  // Header and write data capture
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frame <= '0;
      shift_in <= '0;
    end else if (mdc_rise) begin
      case (state)
        padv_pkg::PADV_S_OP: frame.op <= {frame.op[0], mdio_in};
        padv_pkg::PADV_S_PHYAD: frame.phyad <= {frame.phyad[3:0], mdio_in};
        padv_pkg::PADV_S_REGAD: frame.regad <= regad_full;
        padv_pkg::PADV_S_DATA: shift_in <= wr_data;
        default: shift_in <= shift_in;
      endcase
    end
  end

  // ==========================================================
  // Read path; identifier reads carry no condition at all
  always_comb begin
    case (regad_full)
      padv_pkg::PADV_REG_IDENT_UPPER: rd_value = phy_ident_upper;
      padv_pkg::PADV_REG_IDENT_LOWER: rd_value = phy_ident_lower;
      padv_pkg::PADV_REG_ADVERTISE: rd_value = adv_view;
      default: rd_value = '0;
    endcase
  end

  // Pin driven from flops: zero in the second turnaround bit, then data MSB first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_shift <= '0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (rd_hit) begin
      rd_shift <= rd_value;
    end else if (mdc_rise && state == padv_pkg::PADV_S_TA && frame.op == padv_pkg::PADV_OP_READ &&
                 frame.phyad == phy_addr && rd_shift_valid(frame.regad)) begin
      if (bit_cnt == 5'h00) begin
        mdio_oe <= 1'b1;
        mdio_out <= 1'b0;
      end else begin
        mdio_out <= rd_shift[15];
        rd_shift <= {rd_shift[14:0], 1'b0};
      end
    end else if (mdc_rise && state == padv_pkg::PADV_S_DATA && mdio_oe) begin
      if (bit_cnt == padv_pkg::PADV_LEN_DATA) begin
        mdio_oe <= 1'b0;
        mdio_out <= 1'b0;
      end else begin
        mdio_out <= rd_shift[15];
        rd_shift <= {rd_shift[14:0], 1'b0};
      end
    end
  end

  function automatic logic rd_shift_valid(input logic [4:0] ra);
    return (ra == padv_pkg::PADV_REG_IDENT_UPPER) || (ra == padv_pkg::PADV_REG_IDENT_LOWER) ||
           (ra == padv_pkg::PADV_REG_ADVERTISE);
  endfunction

  // ==========================================================
  // Identifier registers: override-gated writes only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phy_ident_upper <= IDENT_RESET.upper;
      phy_ident_lower <= IDENT_RESET.lower;
    end else if (wr_stb && cmd_override) begin
      if (frame.regad == padv_pkg::PADV_REG_IDENT_UPPER) begin
        phy_ident_upper <= wr_data;
      end
      if (frame.regad == padv_pkg::PADV_REG_IDENT_LOWER) begin
        phy_ident_lower <= wr_data;
      end
    end
  end

  // ==========================================================
  // Advertisement write mask follows override bit and config source
  always_comb begin
    adv_wmask = padv_pkg::PADV_ADV_RW_MASK;
    if (cmd_override) begin
      adv_wmask = adv_wmask | padv_pkg::PADV_ADV_OVR_WRITE_MASK;
      if (config_source_pin) begin
        adv_wmask = adv_wmask | padv_pkg::PADV_ADV_TECH_MASK;
      end
    end
  end

  // Masked bits keep their value, so read-only bits simply ignore the write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      autoneg_advertise <= padv_pkg::PADV_ADV_RESET;
    end else if (wr_stb && frame.regad == padv_pkg::PADV_REG_ADVERTISE) begin
      autoneg_advertise <= (autoneg_advertise & ~adv_wmask) | (wr_data & adv_wmask);
    end
  end

  // Reserved bits may hold a stored value but always read as zero
  assign adv_view = autoneg_advertise & padv_pkg::PADV_ADV_READ_MASK;

  padv_lcw_sender u_lcw (
    .ref_clk(ref_clk),
    .rst(rst),
    .an_enable(an_enable),
    .adv_view(adv_view),
    .lcw_load(lcw_load),
    .lcw_shift(lcw_shift),
    .lcw_word(lcw_word),
    .lcw_bit(lcw_bit)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic adv_wr;
  assign adv_wr = wr_stb && frame.regad == padv_pkg::PADV_REG_ADVERTISE;

  a_ident_reset: assert property ($fell(rst) |->
    (phy_ident_upper == IDENT_RESET.upper && phy_ident_lower == IDENT_RESET.lower))
    else $error("Identifier registers wrong after reset");

  a_adv_reset: assert property ($fell(rst) |-> adv_view == padv_pkg::PADV_ADV_RESET)
    else $error("Advertisement wrong after reset");

  a_ident_locked: assert property ((wr_stb && !cmd_override) |=>
    ($stable(phy_ident_upper) && $stable(phy_ident_lower)))
    else $error("Identifier changed without override");

  a_ident_write: assert property ((wr_stb && cmd_override &&
    frame.regad == padv_pkg::PADV_REG_IDENT_LOWER) |=> phy_ident_lower == $past(wr_data))
    else $error("Identifier write with override lost");

  a_rw_bits: assert property (adv_wr |=>
    (adv_view[padv_pkg::PADV_ADV_NEXT_PAGE] == $past(wr_data[padv_pkg::PADV_ADV_NEXT_PAGE]) &&
     adv_view[padv_pkg::PADV_ADV_REMOTE_FAULT] == $past(wr_data[padv_pkg::PADV_ADV_REMOTE_FAULT])))
    else $error("Read/write advertisement bits not written");

  a_cw_dropped: assert property ((adv_wr && !cmd_override) |=>
    $stable(autoneg_advertise & ~padv_pkg::PADV_ADV_RW_MASK))
    else $error("Override-writable bit changed without override");

  a_tech_hw_ro: assert property ((adv_wr && !config_source_pin) |=>
    $stable(adv_view & padv_pkg::PADV_ADV_TECH_MASK))
    else $error("Technology bits written in hardware mode");

  a_rsvd_zero: assert property ((mdio_oe && state == padv_pkg::PADV_S_DATA &&
    frame.regad == padv_pkg::PADV_REG_ADVERTISE && bit_cnt >= 5'h01 && bit_cnt <= 5'h06 &&
    bit_cnt != 5'h02) |-> !mdio_out)
    else $error("Reserved advertisement bit driven as one");

  a_read_turn: assert property (rd_hit |-> ##[1:200] (mdio_oe && !mdio_out))
    else $error("Read hit never answered with turnaround zero");

  c_read_frame: cover property (rd_hit ##[1:200] $fell(mdio_oe));
  c_write_ok: cover property (adv_wr && cmd_override && config_source_pin);
  c_write_refused: cover property (wr_stb && !cmd_override);

endmodule // padv_mgmt_regs

//--- padv_pkg.sv
package padv_pkg;

  // ==========================================================
  // Register map and frame format
  localparam logic [4:0] PADV_REG_IDENT_UPPER = 5'h02;
  localparam logic [4:0] PADV_REG_IDENT_LOWER = 5'h03;
  localparam logic [4:0] PADV_REG_ADVERTISE = 5'h04;
  localparam logic [5:0] PADV_PREAMBLE_LEN = 6'h20;
  localparam logic [1:0] PADV_OP_READ = 2'h2;
  localparam logic [1:0] PADV_OP_WRITE = 2'h1;
  localparam logic [4:0] PADV_LEN_OP = 5'h01;
  localparam logic [4:0] PADV_LEN_ADDR = 5'h04;
  localparam logic [4:0] PADV_LEN_TA = 5'h01;
  localparam logic [4:0] PADV_LEN_DATA = 5'h0f;

  // ==========================================================
  // Advertisement field layout and reset value
  localparam int PADV_ADV_NEXT_PAGE = 15;
  localparam int PADV_ADV_REMOTE_FAULT = 13;
  localparam logic [15:0] PADV_ADV_RESET = 16'h01e1;
  localparam logic [15:0] PADV_ADV_RW_MASK = 16'ha000;
  localparam logic [15:0] PADV_ADV_OVR_WRITE_MASK = 16'h5c1f;
  localparam logic [15:0] PADV_ADV_TECH_MASK = 16'h01e0;
  localparam logic [15:0] PADV_ADV_READ_MASK = 16'ha1ff;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    PADV_S_PREAMBLE, PADV_S_START, PADV_S_OP, PADV_S_PHYAD, PADV_S_REGAD, PADV_S_TA,
    PADV_S_DATA
  } padv_smi_state_e;

  typedef struct packed {
    logic [1:0] op;
    logic [4:0] phyad;
    logic [4:0] regad;
  } padv_frame_s;

  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
  } padv_ident_s;

  // Identifier word k (1..24) is octet (k-1)/8, bit (k-1)%8, LSB first
  function automatic padv_ident_s padv_ident_reset(input logic [23:0] oui,
                                                   input logic [5:0] model,
                                                   input logic [3:0] rev);
    padv_ident_s r;
    int o;
    int b;
    r = '0;
    for (int k = 3; k <= 24; k++) begin
      o = (k - 1) / 8;
      b = (k - 1) % 8;
      if (k <= 18) begin
        r.upper[18 - k] = oui[16 - 8 * o + b];
      end else begin
        r.lower[34 - k] = oui[16 - 8 * o + b];
      end
    end
    r.lower[9:4] = model;
    r.lower[3:0] = rev;
    return r;
  endfunction

endpackage

//--- padv_mdc_edge.sv
`timescale 1ns/1ps
// ==========================================================
// Management clock rising-edge detector
module padv_mdc_edge (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mdc,
  output logic mdc_rise
);

  logic mdc_prev;

  // Previous level; pin is taken as synchronous already
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mdc_prev <= 1'b1;
    end else begin
      mdc_prev <= mdc;
    end
  end

  // Held high in reset so a stuck-high clock gives no false edge
  assign mdc_rise = mdc & ~mdc_prev;

endmodule // padv_mdc_edge

//--- padv_lcw_sender.sv
`timescale 1ns/1ps
// ==========================================================
// Link code word holder and serialiser for fast link pulses
module padv_lcw_sender (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic an_enable,
  input wire logic [15:0] adv_view,
  input wire logic lcw_load,
  input wire logic lcw_shift,
  output logic [15:0] lcw_word,
  output logic lcw_bit
);

  // Page is captured whole so a mid-page register write cannot tear it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lcw_word <= '0;
      lcw_bit <= 1'b0;
    end else if (lcw_load && an_enable) begin
      lcw_word <= adv_view;
      lcw_bit <= adv_view[0];
    end else if (lcw_shift && an_enable) begin
      lcw_word <= {1'b0, lcw_word[15:1]};
      lcw_bit <= lcw_word[1];
    end
  end

  // ==========================================================
  // Checks
  a_lcw_load: assert property (@(posedge ref_clk) disable iff (rst)
    (lcw_load && an_enable) |=> (lcw_word == $past(adv_view) && lcw_bit == lcw_word[0]))
    else $error("Link code word not taken from advertisement");

  c_lcw_load: cover property (@(posedge ref_clk) disable iff (rst) lcw_load && an_enable);

endmodule // padv_lcw_sender

//--- padv_station_mgr.sv
`timescale 1ns/1ps
// ==========================================================
// Station manager model on the management pins
module padv_station_mgr (
  input wire logic ref_clk,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdc,
  output logic mdio_line
);
  int half = 1;
  logic keep_rsv = 1'b1;
  logic drv = 1'b1;
  logic drv_en = 1'b0;

  // Pull-up holds the line high when nobody drives it
  assign mdio_line = mdio_oe ? mdio_out : (drv_en ? drv : 1'b1);
  // Clock stands low between frames
  initial mdc = 1'b0;

  // One bit time; line is sampled just before the rising edge
  task automatic bit_time(input logic b, input logic en, output logic s, output logic o);
    repeat (half) @(posedge ref_clk);
    #1;
    mdc = 1'b0;
    drv = b;
    drv_en = en;
    repeat (half) @(posedge ref_clk);
    #1;
    s = mdio_line;
    o = mdio_oe;
    mdc = 1'b1;
  endtask

  // Whole frame; reads release the line from turnaround onwards
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd, output logic drove);
    logic [13:0] hdr;
    logic s;
    logic o;
    logic rdop;
    rdop = (op == 2'h2);
    if (!rdop && keep_rsv && ra == 5'h04) begin
      wd = wd & 16'ha3ff;
    end
    hdr = {2'h1, op, pa, ra};
    drove = 1'b0;
    rd = '0;
    for (int i = 0; i < 32; i++) bit_time(1'b1, 1'b1, s, o);
    for (int i = 13; i >= 0; i--) bit_time(hdr[i], 1'b1, s, o);
    bit_time(1'b1, !rdop, s, o);
    bit_time(1'b0, !rdop, s, o);
    for (int i = 15; i >= 0; i--) begin
      bit_time(wd[i], !rdop, s, o);
      rd[i] = s;
      drove = drove | o;
    end
    repeat (half) @(posedge ref_clk);
    #1;
    mdc = 1'b0;
    drv_en = 1'b0;
  endtask
endmodule // padv_station_mgr

//--- tb_phy_id_and_an_advert_regs.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the identifier and advertisement registers
module tb_phy_id_and_an_advert_regs;
  localparam logic [23:0] OUI = 24'h5a3c96; // Arbitrary value
  localparam logic [5:0] MODEL = 6'h2b; // Arbitrary value
  localparam logic [3:0] REV = 4'h7; // Arbitrary value
  logic ref_clk, rst, mdc, mdio_line, mdio_out, mdio_oe, lcw_bit;
  logic cmd_override, config_source_pin, an_enable, lcw_load, lcw_shift;
  logic [4:0] phy_addr;
  logic [15:0] lcw_word, adv_view, adv, rd, id_u, id_l, wd;
  logic [31:0] seed = 32'h0000000a;
  logic dv, ovr, cfg;
  int bad_count = 0;
  int check_count = 0;

  padv_mgmt_regs #(.OUI_VALUE(OUI), .MODEL_VALUE(MODEL), .REVISION_VALUE(REV)) dut (
    .ref_clk(ref_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .phy_addr(phy_addr), .cmd_override(cmd_override),
    .config_source_pin(config_source_pin), .an_enable(an_enable), .lcw_load(lcw_load),
    .lcw_shift(lcw_shift), .lcw_word(lcw_word), .lcw_bit(lcw_bit), .adv_view(adv_view)
  );
  padv_station_mgr sm (
    .ref_clk(ref_clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
    .mdio_line(mdio_line)
  );

  // ==========================================================
  // Clock, helpers and expectations
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Serial order: octets left to right, each LSB first; bits 1 and 2 are not held
  function automatic logic [31:0] exp_ident();
    logic [31:0] r;
    r = '0;
    for (int k = 3; k <= 24; k++) r[34 - k] = OUI[(2 - (k - 1) / 8) * 8 + (k - 1) % 8];
    r[9:4] = MODEL;
    r[3:0] = REV;
    return r;
  endfunction

  // Stored advertisement after a write; bit 9 is never kept
  function automatic logic [15:0] adv_next(input logic [15:0] s, input logic [15:0] w,
                                           input logic o, input logic c);
    s[15] = w[15];
    s[13] = w[13];
    if (o) {s[14], s[12:10], s[4:0]} = {w[14], w[12:10], w[4:0]};
    if (o && c) s[8:5] = w[8:5];
    s[9] = 1'b0;
    return s;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    sm.frame(2'h1, phy_addr, ra, d, rd, dv);
  endtask

  task automatic rdchk(input logic [4:0] ra, input logic [15:0] exp, input string what);
    sm.frame(2'h2, phy_addr, ra, 16'h0000, rd, dv);
    chk(rd, exp, what);
  endtask

  task automatic lcw(input logic l, input logic s);
    @(posedge ref_clk);
    #1;
    lcw_load = l;
    lcw_shift = s;
    @(posedge ref_clk);
    #1;
    lcw_load = 1'b0;
    lcw_shift = 1'b0;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    adv = 16'h01e1;
    {id_u, id_l} = exp_ident();
  endtask

  task finish_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard, sized well above the longest frame sequence
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {cmd_override, config_source_pin, an_enable, lcw_load, lcw_shift} = '0;
    phy_addr = 5'(rnd());
    do_reset();
    chk(adv_view, 16'h01e1, "adv reset view");
    rdchk(5'h02, id_u, "ident upper reset");
    rdchk(5'h03, id_l, "ident lower reset");
    rdchk(5'h04, 16'h01e1, "adv reset read");
    // Identifier writes refused, then taken under override
    for (int i = 0; i < 4; i++) begin
      cmd_override = i[1];
      wd = 16'(rnd());
      wr(5'h02 + i[0], wd);
      if (i[1] && !i[0]) id_u = wd;
      if (i[1] && i[0]) id_l = wd;
      rdchk(5'h02, id_u, "ident upper write");
      rdchk(5'h03, id_l, "ident lower write");
    end
    // Advertisement writes; first three are hand-picked corners
    for (int i = 0; i < 24; i++) begin
      ovr = (i < 3) ? (i != 2) : 1'(rnd());
      cfg = (i < 3) ? (i != 0) : 1'(rnd());
      wd = (i == 1) ? 16'h0000 : ((i < 3) ? 16'hffff : 16'(rnd()));
      sm.keep_rsv = (i < 3) ? (i == 1) : 1'(rnd());
      sm.half = int'(rnd() % 32'h3) + 1;
      cmd_override = ovr;
      config_source_pin = cfg;
      if (sm.keep_rsv) wd = wd & 16'ha3ff;
      wr(5'h04, wd);
      adv = adv_next(adv, wd, ovr, cfg);
      chk(adv_view, adv & 16'ha1ff, "adv view");
      rdchk(5'h04, adv & 16'ha1ff, "adv read");
    end
    sm.half = 1;
    sm.keep_rsv = 1'b1;
    // Foreign address and illegal opcode change nothing
    sm.frame(2'h2, phy_addr + 5'h01, 5'h03, 16'h0000, rd, dv);
    chk({15'h0000, dv}, 16'h0000, "foreign read drove");
    cmd_override = 1'b1;
    sm.frame(2'h1, phy_addr + 5'h01, 5'h02, ~id_u, rd, dv);
    sm.frame(2'h3, phy_addr, 5'h02, ~id_u, rd, dv);
    rdchk(5'h02, id_u, "ident after ignored");
    // Link code word follows the advertisement
    an_enable = 1'b1;
    lcw(1'b1, 1'b0);
    chk(lcw_word, adv & 16'ha1ff, "lcw load");
    chk({15'h0000, lcw_bit}, {15'h0000, adv[0]}, "lcw bit");
    lcw(1'b0, 1'b1);
    chk(lcw_word, (adv & 16'ha1ff) >> 1, "lcw shift");
    chk({15'h0000, lcw_bit}, {15'h0000, adv[1]}, "lcw shift bit");
    lcw(1'b1, 1'b1);
    chk(lcw_word, adv & 16'ha1ff, "lcw load wins");
    an_enable = 1'b0;
    lcw(1'b0, 1'b1);
    chk(lcw_word, adv & 16'ha1ff, "lcw idle");
    // Second reset restores defaults
    do_reset();
    chk(adv_view, 16'h01e1, "adv after reset");
    chk(lcw_word, 16'h0000, "lcw after reset");
    rdchk(5'h03, id_l, "ident lower again");
    finish_test();
  end
endmodule // tb_phy_id_and_an_advert_regs
